// ---- src/ddrb2_pkg.sv ----
package ddrb2_pkg;
	// organization defaults: four 9-bit lanes give the 36-bit word
	localparam int LANE_W_DEF     = 9;
	localparam int LANES_DEF      = 4;
	localparam int ADDR_W_DEF     = 8;
	// write queue depth between the capture stage and the array
	localparam int FIFO_DEPTH_DEF = 16;
	// least spacing of commands, in clock edges, so beat pairs never overlap
	localparam int CMD_SPACING    = 2;
	// write commands are refused once the queue has fewer free slots than this
	localparam int FIFO_MARGIN    = 3;
	// command pin levels
	localparam logic LOAD_IDLE    = 1'b1;
	localparam logic RNW_READ     = 1'b1;
	// driver and termination levels out of reset
	localparam logic OE_RST       = 1'b0;
	localparam logic TERM_RST     = 1'b0;
endpackage : ddrb2_pkg

// ---- src/ddrb2_sram.sv ----
`timescale 1ns/1ps
`default_nettype none


// queue of write bursts between capture and the array
module ddrb2_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic                       s_valid,
	input  wire logic [W-1:0]               s_data,
	output logic                            s_ready,
	output logic                            m_valid,
	output logic [W-1:0]                    m_data,
	input  wire logic                       m_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] nxt_wr_ptr;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW-1:0] nxt_rd_ptr;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          push;
	logic          pop;

	// handshakes and pointer steps
	always_comb begin
		push       = s_valid && (cnt_ff != CW'(DEPTH));
		pop        = m_ready && (cnt_ff != '0);
		nxt_wr_ptr = push ? PW'((32'(wr_ptr_ff) + 1) % DEPTH) : wr_ptr_ff;
		nxt_rd_ptr = pop ? PW'((32'(rd_ptr_ff) + 1) % DEPTH) : rd_ptr_ff;
		nxt_cnt    = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + CW'(1);
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff    <= nxt_cnt;
		end
	end

	// storage holds no reset; entries are only read once written
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= s_data;
		end
	end

	assign s_ready = (cnt_ff != CW'(DEPTH));
	assign m_valid = (cnt_ff != '0);
	assign m_data  = mem_ff[rd_ptr_ff];
	assign level   = cnt_ff;
endmodule // ddrb2_fifo

// command decode, late-write capture with lane masks, pipelined read
module ddrb2_sram
	import ddrb2_pkg::*;
#(
	parameter int LANE_W     = LANE_W_DEF,
	parameter int LANES      = LANES_DEF,
	parameter int ADDR_W     = ADDR_W_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   load_strobe_n,
	input  wire logic                   read_not_write,
	input  wire logic [ADDR_W-1:0]      addr,
	input  wire logic [LANES*LANE_W-1:0] dq_in,
	input  wire logic [LANES-1:0]       byte_lane_enable_n,
	input  wire logic                   input_termination_select,
	input  wire logic                   array_hold,
	output logic [LANES*LANE_W-1:0]     dq_out,
	output logic                        dq_oe,
	output logic                        dq_term_on,
	output logic                        write_accept,
	output logic                        write_pending
);
	localparam int W  = LANES*LANE_W;
	localparam int FW = ADDR_W + 2*W + 2*LANES;
	localparam int CW = $clog2(FIFO_DEPTH+1);

	// array entry holds both beats: second beat high, first beat low
	logic [2*W-1:0]    array_ff [2**ADDR_W];

	// command decode and capture stages
	logic              cmd_wr;
	logic              cmd_rd;
	logic              cmd_idle;
	logic              wr_s1_ff;
	logic              nxt_wr_s1;
	logic              wr_s2_ff;
	logic              nxt_wr_s2;
	logic [ADDR_W-1:0] wr_addr_ff;
	logic [ADDR_W-1:0] nxt_wr_addr;
	logic [W-1:0]      beat1_ff;
	logic [W-1:0]      nxt_beat1;
	logic [LANES-1:0]  en1_n_ff;
	logic [LANES-1:0]  nxt_en1_n;

	// read pipeline and driver control
	logic              rd_s1_ff;
	logic              nxt_rd_s1;
	logic              rd_s2_ff;
	logic              nxt_rd_s2;
	logic              rd_s3_ff;
	logic              nxt_rd_s3;
	logic [ADDR_W-1:0] rd_addr_ff;
	logic [ADDR_W-1:0] nxt_rd_addr;
	logic [2*W-1:0]    rd_word_ff;
	logic [2*W-1:0]    nxt_rd_word;
	logic              off_s1_ff;
	logic              nxt_off_s1;
	logic              off_s2_ff;
	logic              nxt_off_s2;
	logic [W-1:0]      dq_out_ff;
	logic [W-1:0]      nxt_dq_out;
	logic              dq_oe_ff;
	logic              nxt_dq_oe;
	logic              dq_term_ff;
	logic              nxt_dq_term;
	logic              accept_ff;
	logic              nxt_accept;
	logic              pending_ff;
	logic              nxt_pending;

	// queue and drain
	logic              push_valid;
	logic [FW-1:0]     push_data;
	logic              push_ready;
	logic              pop_valid;
	logic [FW-1:0]     pop_data;
	logic [CW-1:0]     q_level;
	logic [ADDR_W-1:0] drain_addr;
	logic [2*W-1:0]    drain_new;
	logic [2*LANES-1:0] drain_en_n;
	logic [2*W-1:0]    drain_old;
	logic [2*W-1:0]    drain_merged;
	logic              beat1_true;
	logic              beat2_true;

	// command decode
	always_comb begin
		cmd_idle = (load_strobe_n == LOAD_IDLE);
		cmd_wr   = !cmd_idle && (read_not_write != RNW_READ) && accept_ff;
		cmd_rd   = !cmd_idle && (read_not_write == RNW_READ);
	end

	// write capture: first beat at n+1, second beat live at n+2
	always_comb begin
		nxt_wr_s1   = cmd_wr;
		nxt_wr_addr = cmd_wr ? addr : wr_addr_ff;
		nxt_wr_s2   = wr_s1_ff;
		// first beat latched as first piece
		nxt_beat1   = wr_s1_ff ? dq_in : beat1_ff;
		// enables sampled with the first beat
		nxt_en1_n   = wr_s1_ff ? byte_lane_enable_n : en1_n_ff;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_s1_ff   <= 1'b0;
			wr_s2_ff   <= 1'b0;
			wr_addr_ff <= '0;
			beat1_ff   <= '0;
			en1_n_ff   <= '1;
		end else begin
			wr_s1_ff   <= nxt_wr_s1;
			wr_s2_ff   <= nxt_wr_s2;
			wr_addr_ff <= nxt_wr_addr;
			beat1_ff   <= nxt_beat1;
			en1_n_ff   <= nxt_en1_n;
		end
	end

	// burst push into the write queue
	always_comb begin
		// beat true when any enable is low
		beat1_true = !(&en1_n_ff);
		beat2_true = !(&byte_lane_enable_n);
		// abort when neither beat is true
		push_valid = wr_s2_ff && (beat1_true || beat2_true);
		// second beat sits above the first
		push_data  = {wr_addr_ff, dq_in, beat1_ff, byte_lane_enable_n, en1_n_ff};
	end

	ddrb2_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_wq (
		.clk     (clk),
		.nrst    (nrst),
		.s_valid (push_valid),
		.s_data  (push_data),
		.s_ready (push_ready),
		.m_valid (pop_valid),
		.m_data  (pop_data),
		.m_ready (!array_hold),
		.level   (q_level)
	);

	// unpack the queue head and fetch the old entry for merging
	always_comb begin
		drain_addr = pop_data[FW-1 -: ADDR_W];
		drain_new  = pop_data[2*LANES +: 2*W];
		drain_en_n = pop_data[2*LANES-1:0];
		drain_old  = array_ff[drain_addr];
	end

	// per-lane, per-beat merge
	genvar gl;
	generate
		for (gl = 0; gl < 2*LANES; gl++) begin : g_lane
			// lane gl gates its own bit field
			// lanes are LANE_W bits wide, nine bits by default
			assign drain_merged[gl*LANE_W +: LANE_W] = drain_en_n[gl] ?
				drain_old[gl*LANE_W +: LANE_W] : drain_new[gl*LANE_W +: LANE_W];
		end
	endgenerate

	// array write port; stalls while the array is held
	always_ff @(posedge clk) begin
		if (pop_valid && !array_hold) begin
			array_ff[drain_addr] <= drain_merged;
		end
	end

	// read pipeline, deselect tracking and driver control
	always_comb begin
		nxt_rd_s1   = cmd_rd;
		nxt_rd_addr = cmd_rd ? addr : rd_addr_ff;
		nxt_rd_s2   = rd_s1_ff;
		// second beat one edge after the first
		nxt_rd_s3   = rd_s2_ff;
		nxt_rd_word = rd_s1_ff ? array_ff[rd_addr_ff] : rd_word_ff;
		// no-op or write schedules a forced-off cycle
		nxt_off_s1  = !cmd_rd;
		nxt_off_s2  = off_s1_ff;
		nxt_dq_out  = dq_out_ff;
		nxt_dq_oe   = 1'b0;
		if (rd_s2_ff) begin
			nxt_dq_out = rd_word_ff[W-1:0];
			nxt_dq_oe  = 1'b1;
		end else if (rd_s3_ff) begin
			nxt_dq_out = rd_word_ff[2*W-1:W];
			nxt_dq_oe  = 1'b1;
		end else if (off_s2_ff) begin
			// forced-off cycle keeps the drivers released
			nxt_dq_oe  = 1'b0;
		end
		// termination follows select while drivers are off
		nxt_dq_term = input_termination_select && !nxt_dq_oe && !rd_s2_ff;
		// writes are refused once the queue lacks its safety margin
		nxt_accept  = (32'(q_level) + FIFO_MARGIN <= FIFO_DEPTH) && push_ready;
		nxt_pending = (q_level != '0) || wr_s1_ff || wr_s2_ff;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_s1_ff   <= 1'b0;
			rd_s2_ff   <= 1'b0;
			rd_s3_ff   <= 1'b0;
			rd_addr_ff <= '0;
			rd_word_ff <= '0;
			off_s1_ff  <= 1'b0;
			off_s2_ff  <= 1'b0;
			dq_out_ff  <= '0;
			dq_oe_ff   <= OE_RST;
			dq_term_ff <= TERM_RST;
			accept_ff  <= 1'b0;
			pending_ff <= 1'b0;
		end else begin
			rd_s1_ff   <= nxt_rd_s1;
			rd_s2_ff   <= nxt_rd_s2;
			rd_s3_ff   <= nxt_rd_s3;
			rd_addr_ff <= nxt_rd_addr;
			rd_word_ff <= nxt_rd_word;
			off_s1_ff  <= nxt_off_s1;
			off_s2_ff  <= nxt_off_s2;
			dq_out_ff  <= nxt_dq_out;
			dq_oe_ff   <= nxt_dq_oe;
			dq_term_ff <= nxt_dq_term;
			accept_ff  <= nxt_accept;
			pending_ff <= nxt_pending;
		end
	end

	// drivers follow the registered enable, high through both beats
	assign dq_oe         = dq_oe_ff;
	assign dq_out        = dq_out_ff;
	assign dq_term_on    = dq_term_ff;
	assign write_accept  = accept_ff;
	assign write_pending = pending_ff;
endmodule // ddrb2_sram

`default_nettype wire

// ---- verification/ddrb2_sram_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// port-level timing checks for the burst-of-two sram block
module ddrb2_sram_chk #(
	parameter int LANE_W = 9,
	parameter int LANES  = 4
) (
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     load_strobe_n,
	input wire logic                     read_not_write,
	input wire logic [LANES-1:0]         byte_lane_enable_n,
	input wire logic                     input_termination_select,
	input wire logic [LANES*LANE_W-1:0]  dq_out,
	input wire logic                     dq_oe,
	input wire logic                     dq_term_on,
	input wire logic                     write_accept,
	input wire logic                     write_pending
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// command and beat shapes
	sequence s_rd; !load_strobe_n && read_not_write; endsequence
	sequence s_wr; !load_strobe_n && !read_not_write && write_accept; endsequence
	sequence s_beat_on; byte_lane_enable_n != '1; endsequence
	sequence s_burst_out; dq_oe ##1 dq_oe; endsequence
	sequence s_rd_desel2; s_rd ##1 load_strobe_n ##1 load_strobe_n; endsequence
	AST_RD_OE: assert property (s_rd |-> ##3 dq_oe)
		else $error("read gave no drive");
	AST_RD_BEAT2: assert property (s_rd |-> ##4 dq_oe)
		else $error("second read beat not driven");
	AST_NOP_OFF: assert property ((load_strobe_n || !read_not_write)
		&& !$past(!load_strobe_n && read_not_write) |-> ##3 !dq_oe)
		else $error("drive after no-op or write");
	AST_DESEL: assert property (s_rd ##1 load_strobe_n |-> ##2 s_burst_out)
		else $error("deselect cut a read");
	AST_RELEASE: assert property (s_rd_desel2 |-> ##3 !dq_oe)
		else $error("drivers not released after read and deselect");
	AST_TERM_OFF: assert property (dq_oe |-> !dq_term_on)
		else $error("termination on while driving");
	AST_TERM_ON: assert property ($past(nrst) && !dq_oe && !$past(dq_oe)
		&& input_termination_select && $past(input_termination_select) |-> dq_term_on)
		else $error("termination off while released");
	AST_WR_PEND: assert property (s_wr ##1 s_beat_on |-> ##[1:2] write_pending)
		else $error("write burst not held");
	AST_DQ_HOLD: assert property (!dq_oe && !$past(dq_oe) |-> $stable(dq_out))
		else $error("read data moved outside a burst");
	AST_ACCEPT: assert property ($past(nrst) && !write_pending |-> write_accept)
		else $error("write refused with empty queue");
endmodule // ddrb2_sram_chk

`default_nettype wire

// ---- verification/ddrb2_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// memory controller side: commands, late-write beats and lane enables
module ddrb2_ctrl_model #(
	parameter int DW = 36,
	parameter int NL = 4
) (
	input wire logic          clk,
	input wire logic          write_accept,
	output logic              strobe_n,
	output logic              rnw,
	output logic [7:0]        addr,
	output logic [DW-1:0]     dq_in,
	output logic [NL-1:0]     lane_en_n
);
	// idle bus at time zero
	initial begin
		strobe_n = 1'b1;
		rnw = 1'b0;
		addr = '0;
		dq_in = '0;
		lane_en_n = '1;
	end
	// write command, then both beats; ok tells whether it was taken
	task automatic wr(input logic [7:0] a, input logic [2*DW-1:0] d,
		input logic [2*NL-1:0] e, output bit ok);
		@(posedge clk);
		strobe_n <= 1'b0;
		rnw <= 1'b0;
		addr <= a;
		@(negedge clk);
		ok = write_accept;
		@(posedge clk);
		strobe_n <= 1'b1;
		rnw <= ~rnw;
		dq_in <= d[DW-1:0];
		lane_en_n <= e[NL-1:0];
		@(posedge clk);
		dq_in <= d[2*DW-1:DW];
		lane_en_n <= e[2*NL-1:NL];
		@(posedge clk);
		dq_in <= ~dq_in;
		lane_en_n <= '1;
	endtask
	// read command followed by a deselect
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		strobe_n <= 1'b0;
		rnw <= 1'b1;
		addr <= a;
		@(posedge clk);
		strobe_n <= 1'b1;
		addr <= ~a;
	endtask
endmodule // ddrb2_ctrl_model

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ddrb2_pkg::*;
	localparam int DW = LANES_DEF*LANE_W_DEF;
	logic              clk, nrst, its, hold, stb_n, rnw, acc, pend, oe, term;
	logic [7:0]        a;
	logic [DW-1:0]     din, dout;
	logic [3:0]        ben;
	logic [2*DW-1:0]   mem [0:255];
	logic [2*DW-1:0]   exq [$];
	logic [2*DW-1:0]   ex;
	logic [95:0]       r;
	logic [31:0]       seed = 32'h0000_0063;
	int                fail_count = 0;
	int                n_compared = 0;
	int                n_ref = 0;
	int                i;

	ddrb2_sram u_dut (.clk(clk), .nrst(nrst), .load_strobe_n(stb_n), .read_not_write(rnw),
		.addr(a), .dq_in(din), .byte_lane_enable_n(ben), .input_termination_select(its),
		.array_hold(hold), .dq_out(dout), .dq_oe(oe), .dq_term_on(term),
		.write_accept(acc), .write_pending(pend));
	ddrb2_ctrl_model #(.DW(DW), .NL(4)) u_ctrl (.clk(clk), .write_accept(acc),
		.strobe_n(stb_n), .rnw(rnw), .addr(a), .dq_in(din), .lane_en_n(ben));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// xorshift source
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// bounded wait until queued writes reach the array
	task automatic wait_idle();
		for (int k = 0; k < 200 && pend !== 1'b0; k++) @(negedge clk);
		if (pend !== 1'b0) begin
			cmp("write_pending", '0, DW'(pend));
			end_of_test();
		end
	endtask

	// write and update the expected array lane by lane
	task automatic do_wr(input logic [7:0] ad, input logic [2*DW-1:0] d, input logic [7:0] e);
		bit ok;
		u_ctrl.wr(ad, d, e, ok);
		if (!ok) n_ref++;
		if (ok) for (int l = 0; l < 8; l++) if (!e[l]) mem[ad][l*9+:9] = d[l*9+:9];
	endtask

	task automatic do_rd(input logic [7:0] ad);
		wait_idle();
		exq.push_back(mem[ad]);
		u_ctrl.rd(ad);
	endtask

	// watcher: each driven burst is checked against the oldest note
	always @(negedge clk) begin
		if (nrst && oe === 1'b1) begin
			ex = exq.size() > 0 ? exq.pop_front() : 'x;
			cmp("read_beat1", ex[DW-1:0], dout);
			@(negedge clk);
			cmp("read_beat2", ex[2*DW-1:DW], dout);
		end
	end

	initial begin
		nrst = 1'b0;
		its = 1'b0;
		hold = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// full writes give known contents
		for (i = 0; i < 40; i++) begin
			r = {xs(), xs(), xs()};
			do_wr(8'(i), r[2*DW-1:0], 8'h00);
		end
		// every lane mask per beat, abort and random masks, then read back
		for (i = 0; i < 24; i++) begin
			r = {xs(), xs(), xs()};
			its <= r[95];
			do_wr(8'(i), r[2*DW-1:0], i < 16 ? {~4'(i), 4'(i)} : (i == 16 ? 8'hff : r[87:80]));
			do_rd(8'(i));
		end
		// stall the array until writes are refused, then drain
		hold <= 1'b1;
		for (i = 16; i < 36; i++) begin
			r = {xs(), xs(), xs()};
			do_wr(8'(i), r[2*DW-1:0], r[87:80]);
		end
		cmp("write_refused", DW'(1), DW'(n_ref > 0));
		hold <= 1'b0;
		for (i = 16; i < 36; i++) do_rd(8'(i));
		for (i = 0; i < 10 && exq.size() > 0; i++) @(posedge clk);
		// let the last second beat and the release be seen
		repeat (4) @(posedge clk);
		cmp("bursts_left", '0, DW'(exq.size()));
		end_of_test();
	end
endmodule // testbench

bind ddrb2_sram ddrb2_sram_chk #(.LANE_W(LANE_W), .LANES(LANES)) u_chk (.clk(clk),
	.nrst(nrst), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
	.byte_lane_enable_n(byte_lane_enable_n), .input_termination_select(input_termination_select),
	.dq_out(dq_out), .dq_oe(dq_oe), .dq_term_on(dq_term_on), .write_accept(write_accept),
	.write_pending(write_pending));

`default_nettype wire
